/* File: hw/usb_top.sv */
// shadow buffer access and fifo status with receive and transmit fifos
`timescale 1ns/100ps
`include "usb_cfg.svh"
module usb_top
    import usb_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // receiver side: byte arriving from the deserializer
    input wire logic rx_serial_strobe_i,
    input wire usb_byte_t rx_serial_byte_i,
    input wire logic rx_ir_strobe_i,
    input wire usb_byte_t rx_ir_byte_i,
    // transmitter side: serializer pulls a byte
    input wire logic tx_take_i,
    output logic tx_valid_o,
    output usb_byte_t tx_byte_o,
    output logic tx_ir_sel_n_o,
    // line status links
    output logic rx_valid_flag_o,
    output logic tx_holding_empty_flag_o,
    output logic overrun_o,
    output logic fifo_enable_o,
    // interrupt
    output logic irq_o
);

    // control state
    logic fifo_en;
    logic next_fifo_en;
    logic ir_mode;
    logic next_ir_mode;
    usb_irq_t irq_stat;
    usb_irq_t next_irq_stat;
    usb_irq_t irq_mask;
    usb_irq_t next_irq_mask;

    // receive state
    logic [3:0] rx_wp;
    logic [3:0] next_rx_wp;
    logic [3:0] rx_rp;
    logic [3:0] next_rx_rp;
    logic [4:0] rx_cnt;
    logic [4:0] next_rx_cnt;

    // transmit state
    logic [3:0] tx_wp;
    logic [3:0] next_tx_wp;
    logic [3:0] tx_rp;
    logic [3:0] next_tx_rp;
    logic [4:0] tx_cnt;
    logic [4:0] next_tx_cnt;

    // bus state
    logic ack;
    logic next_ack;
    logic err;
    logic next_err;
    logic [31:0] rdat;
    logic [31:0] next_rdat;
    logic rd_pend;
    logic next_rd_pend;

    // overrun pulse
    logic ovr;
    logic next_ovr;

    function automatic logic is_shadow(input logic [31:0] a);
        is_shadow = (a >= `USB_SHADOW_BASE) && (a <= `USB_SHADOW_LAST) && (a[1:0] == 2'b00);
    endfunction

    // pick the byte source for the current mode
    logic rx_in_stb;
    usb_byte_t rx_in_byte;
    always_comb begin
        rx_in_stb = ir_mode ? rx_ir_strobe_i : rx_serial_strobe_i;
        rx_in_byte = ir_mode ? rx_ir_byte_i : rx_serial_byte_i;
    end

    // depth in use: one entry when fifos off
    logic [4:0] depth;
    always_comb begin
        depth = fifo_en ? 5'(`USB_FIFO_DEPTH) : 5'h01;
    end

    logic req;
    logic shadow_hit;
    logic rd_pop;
    logic wr_push;
    logic wr_over;
    logic rx_full;
    logic tx_full;
    always_comb begin
        // a request is taken once; a pending answer blocks a second take
        req = cyc_i && stb_i && !ack && !err && !rd_pend;
        shadow_hit = is_shadow(adr_i);
        rx_full = (rx_cnt == depth);
        tx_full = (tx_cnt == depth);
        rd_pop = req && !we_i && shadow_hit && (rx_cnt != 5'h00);
        wr_push = req && we_i && sel_i[0] && shadow_hit && !tx_full;

        // fifos off and holding full: overwrite the held byte
        wr_over = req && we_i && sel_i[0] && shadow_hit && tx_full && !fifo_en;
    end

    logic rx_push;
    logic rx_over;
    logic tx_pop;
    always_comb begin
        rx_push = rx_in_stb && !rx_full;
        rx_over = rx_in_stb && rx_full && !fifo_en;
        tx_pop = tx_take_i && (tx_cnt != 5'h00);
    end

    // receive memory
    logic rx_mem_we;
    logic [3:0] rx_mem_wa;
    usb_byte_t rx_head;
    always_comb begin
        rx_mem_we = rx_push || rx_over;
        rx_mem_wa = rx_over ? rx_rp : rx_wp;
    end
    // head follows the current pointer, so a pop returns the entry it removes
    usb_mem u_rx_mem (
        .clk_i(clk_i),
        .we_i(rx_mem_we),
        .waddr_i(rx_mem_wa),
        .wdata_i(rx_in_byte),
        .raddr_i(rx_rp),
        .rdata_o(rx_head)
    );

    // transmit memory
    logic tx_mem_we;
    logic [3:0] tx_mem_wa;
    usb_byte_t tx_head;
    always_comb begin
        tx_mem_we = wr_push || wr_over;
        tx_mem_wa = wr_over ? tx_rp : tx_wp;
    end
    usb_mem u_tx_mem (
        .clk_i(clk_i),
        .we_i(tx_mem_we),
        .waddr_i(tx_mem_wa),
        .wdata_i(dat_i[7:0]),
        .raddr_i(next_tx_rp),
        .rdata_o(tx_head)
    );

    // fifo pointers and counts
    // fifos off: pointers stay at entry zero and the count stops at one
    always_comb begin
        next_rx_wp = rx_wp;
        next_rx_rp = rx_rp;
        next_rx_cnt = rx_cnt;
        if (rx_push) begin
            next_rx_wp = fifo_en ? rx_wp + 4'h1 : rx_wp;
        end
        if (rd_pop) begin
            next_rx_rp = fifo_en ? rx_rp + 4'h1 : rx_rp;
        end
        next_rx_cnt = rx_cnt + {4'h0, rx_push} - {4'h0, rd_pop};

        next_tx_wp = tx_wp;
        next_tx_rp = tx_rp;
        if (wr_push) begin
            next_tx_wp = fifo_en ? tx_wp + 4'h1 : tx_wp;
        end
        if (tx_pop) begin
            next_tx_rp = fifo_en ? tx_rp + 4'h1 : tx_rp;
        end
        next_tx_cnt = tx_cnt + {4'h0, wr_push} - {4'h0, tx_pop};

        // toggling fifo mode flushes both queues
        if (next_fifo_en != fifo_en) begin
            next_rx_wp = 4'h0;
            next_rx_rp = 4'h0;
            next_rx_cnt = 5'h00;
            next_tx_wp = 4'h0;
            next_tx_rp = 4'h0;
            next_tx_cnt = 5'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_cnt <= 5'h00;
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_cnt <= 5'h00;
        end else begin
            rx_wp <= next_rx_wp;
            rx_rp <= next_rx_rp;
            rx_cnt <= next_rx_cnt;
            tx_wp <= next_tx_wp;
            tx_rp <= next_tx_rp;
            tx_cnt <= next_tx_cnt;
        end
    end

    // status word, rebuilt each cycle from counts
    logic [31:0] status_word;
    always_comb begin
        // reserved bits read as zero
        status_word = 32'h0000_0000;
        status_word[`USB_ST_RX_FULL] = (rx_cnt == depth);
        status_word[`USB_ST_RX_AVAIL] = (rx_cnt != 5'h00);
        status_word[`USB_ST_TX_EMPTY] = (tx_cnt == 5'h00);
        status_word[`USB_ST_TX_ROOM] = (tx_cnt != depth);
    end

    // overrun from both modes
    always_comb begin
        next_ovr = rx_over || (rx_in_stb && rx_full && fifo_en);
    end

    // control, interrupt and bus answer
    usb_irq_t irq_ev;
    always_comb begin
        next_fifo_en = fifo_en;
        next_ir_mode = ir_mode;
        next_irq_mask = irq_mask;
        next_ack = 1'b0;
        next_err = 1'b0;
        next_rdat = rdat;
        next_rd_pend = 1'b0;
        // each source raises its event for one cycle
        irq_ev = 3'h0;
        irq_ev[`USB_IRQ_OVERRUN] = next_ovr;
        irq_ev[`USB_IRQ_RXAVAIL] = rx_push;
        irq_ev[`USB_IRQ_TXEMPTY] = tx_pop && (tx_cnt == 5'h01);
        next_irq_stat = irq_stat;

        if (req) begin
            if (shadow_hit) begin
                if (we_i) begin
                    next_ack = 1'b1;
                end else begin
                    // memory head is registered, answer one cycle later
                    next_rd_pend = 1'b1;
                end
            end else if (adr_i == `USB_STATUS_ADDR) begin
                next_ack = 1'b1;
                next_rdat = status_word;
            end else if (adr_i == `USB_CTRL_ADDR) begin
                next_ack = 1'b1;
                next_rdat = {30'h0, ir_mode, fifo_en};
                if (we_i && sel_i[0]) begin
                    next_fifo_en = dat_i[`USB_CTRL_FIFO_EN];
                    next_ir_mode = dat_i[`USB_CTRL_IR_MODE];
                end
            end else if (adr_i == `USB_IRQ_STAT_ADDR) begin
                next_ack = 1'b1;
                next_rdat = {29'h0, irq_stat};
                if (we_i && sel_i[0]) begin
                    next_irq_stat = irq_stat & ~dat_i[2:0];
                end
            end else if (adr_i == `USB_IRQ_MASK_ADDR) begin
                next_ack = 1'b1;
                next_rdat = {29'h0, irq_mask};
                if (we_i && sel_i[0]) begin
                    next_irq_mask = dat_i[2:0];
                end
            end else begin
                next_err = 1'b1;
                next_rdat = 32'h0000_0000;
            end
        end

        // shadow read: answer with the head captured at the pop
        if (rd_pend) begin
            next_ack = 1'b1;
            next_rdat = {24'h00_0000, rx_head};
        end

        // set wins over clear
        next_irq_stat = next_irq_stat | irq_ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_en <= 1'b0;
            ir_mode <= 1'b0;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            ack <= 1'b0;
            err <= 1'b0;
            rdat <= 32'h0000_0000;
            rd_pend <= 1'b0;
            ovr <= 1'b0;
        end else begin
            fifo_en <= next_fifo_en;
            ir_mode <= next_ir_mode;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            ack <= next_ack;
            err <= next_err;
            rdat <= next_rdat;
            rd_pend <= next_rd_pend;
            ovr <= next_ovr;
        end
    end

    // registered outputs to the line logic and serializer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_ir_sel_n_o <= 1'b1;
            rx_valid_flag_o <= 1'b0;
            tx_holding_empty_flag_o <= 1'b1;
            irq_o <= 1'b0;
        end else begin
            // valid only once the head register shows a byte written into an empty queue
            tx_valid_o <= (next_tx_cnt != 5'h00) && (tx_cnt != 5'h00);
            tx_ir_sel_n_o <= !next_ir_mode;
            rx_valid_flag_o <= (next_rx_cnt != 5'h00);
            tx_holding_empty_flag_o <= (next_tx_cnt == 5'h00);
            irq_o <= |(next_irq_stat & next_irq_mask);
        end
    end

    always_comb begin
        // head byte straight from the memory's read register
        tx_byte_o = tx_head;
        dat_o = rdat;
        ack_o = ack;
        err_o = err;
        overrun_o = ovr;
        fifo_enable_o = fifo_en;
    end
endmodule

/* File: hw/usb_cfg.svh */
// constants for the shadow buffer and fifo status block
// Summary of operation
// - sixteen word locations alias the receive buffer and transmit holding register.
// - shadow read returns received byte in bits 7:0, serial or infrared input.
// - fifos off: new byte overwrites unread buffer and flags overrun.
// - fifos on: shadow read returns and removes oldest receive entry.
// - receive fifo full: keep contents, drop incoming byte, flag overrun.
// - written byte goes out serially, or on active-low infrared output.
// - fifos off: write clears holding empty; later writes replace held byte.
// - fifos on: accept writes up to fifo depth of sixteen.
// - transmit write to a full fifo is discarded.
// - status bit 4 is receive fifo full, resets zero.
// - status bit 3 is receive fifo not empty, resets zero.
// - status bit 2 is transmit fifo empty, resets one.
// - status bit 1 is transmit fifo not full, resets one.
`ifndef USB_CFG_SVH
`define USB_CFG_SVH
`define USB_SHADOW_BASE 32'h5000_1130
`define USB_SHADOW_LAST 32'h5000_116C
`define USB_STATUS_ADDR 32'h5000_117C
`define USB_CTRL_ADDR 32'h5000_11A0
`define USB_IRQ_STAT_ADDR 32'h5000_11A4
`define USB_IRQ_MASK_ADDR 32'h5000_11A8
`define USB_CTRL_FIFO_EN 0
`define USB_CTRL_IR_MODE 1
`define USB_ST_RX_FULL 4
`define USB_ST_RX_AVAIL 3
`define USB_ST_TX_EMPTY 2
`define USB_ST_TX_ROOM 1
`define USB_IRQ_OVERRUN 0
`define USB_IRQ_RXAVAIL 1
`define USB_IRQ_TXEMPTY 2
`define USB_FIFO_DEPTH 16
`define USB_PTR_W 4
`define USB_CNT_W 5
`endif

/* File: hw/usb_pkg.sv */
// types for the shadow buffer and fifo status block
package usb_pkg;
    typedef logic [7:0] usb_byte_t;
    typedef logic [2:0] usb_irq_t;
endpackage

/* File: hw/usb_mem.sv */
// small dual-port byte memory with registered read data
`timescale 1ns/100ps
module usb_mem
    import usb_pkg::*;
(
    // clock
    input wire logic clk_i,
    // write port
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire usb_byte_t wdata_i,
    // read port
    input wire logic [3:0] raddr_i,
    output usb_byte_t rdata_o
);
    usb_byte_t mem [0:15];
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

/* File: tb/usb_checker.sv */
// bus, flag and transmit-hold assertions for the shadow buffer block
`timescale 1ns/100ps
`include "usb_cfg.svh"
module usb_checker
    import usb_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    // serial side
    input wire logic rx_serial_strobe_i,
    input wire logic rx_ir_strobe_i,
    input wire logic tx_take_i,
    input wire logic tx_valid_o,
    input wire usb_byte_t tx_byte_o,
    input wire logic tx_ir_sel_n_o,
    // flags
    input wire logic rx_valid_flag_o,
    input wire logic tx_holding_empty_flag_o,
    input wire logic overrun_o,
    input wire logic fifo_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic shd;
    logic rd;
    assign shd = adr_i >= `USB_SHADOW_BASE && adr_i <= `USB_SHADOW_LAST;
    assign rd = ack_o && !we_i && adr_i == `USB_STATUS_ADDR;
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_ack_xor_err: assert property (!(ack_o && err_o)) else $error("ack with err");
    a_write_ack: assert property ($rose(stb_i) && cyc_i && we_i && shd |=> ack_o)
        else $error("shadow write not acked");
    a_read_late: assert property ($rose(stb_i) && cyc_i && !we_i && shd
        |=> !ack_o ##1 ack_o && dat_o[31:8] == 24'h000000) else $error("bad read");
    a_status_sane: assert property (rd |-> dat_o[31:5] == 27'h0 && !dat_o[0]
        && !(dat_o[4] && !dat_o[3]) && !(dat_o[2] && !dat_o[1]))
        else $error("status incoherent");
    a_rx_ready: assert property (rx_serial_strobe_i && tx_ir_sel_n_o |=> rx_valid_flag_o)
        else $error("no ready");
    a_overrun_cause: assert property (overrun_o |-> $past(rx_serial_strobe_i || rx_ir_strobe_i))
        else $error("overrun without byte");
    a_single_hold: assert property (!fifo_enable_o && tx_valid_o |-> !tx_holding_empty_flag_o)
        else $error("holding flag wrong");
    a_tx_steady: assert property (tx_valid_o && !tx_take_i && !(cyc_i && stb_i && we_i)
        |=> tx_valid_o && $stable(tx_byte_o)) else $error("tx head moved");
    a_unmapped_err: assert property ($rose(stb_i) && cyc_i && adr_i == 32'h5000_1200
        |=> err_o) else $error("no err");
endmodule
bind usb_top usb_checker chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .rx_serial_strobe_i(rx_serial_strobe_i), .rx_ir_strobe_i(rx_ir_strobe_i),
    .tx_take_i(tx_take_i), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
    .tx_ir_sel_n_o(tx_ir_sel_n_o), .rx_valid_flag_o(rx_valid_flag_o),
    .tx_holding_empty_flag_o(tx_holding_empty_flag_o), .overrun_o(overrun_o),
    .fifo_enable_o(fifo_enable_o));

/* File: tb/usb_peer.sv */
// serial peer: sends received bytes, takes transmit bytes unless stalled
`timescale 1ns/100ps
module usb_peer
    import usb_pkg::*;
(
    // control
    input wire logic clk_i,
    input wire logic stall_i,
    // transmit pull
    input wire logic tx_valid_i,
    input wire usb_byte_t tx_byte_i,
    output logic tx_take_o,
    output logic got_o,
    output usb_byte_t got_byte_o,
    // receive push
    output logic ser_stb_o,
    output usb_byte_t ser_byte_o,
    output logic ir_stb_o,
    output usb_byte_t ir_byte_o
);
    initial begin
        {tx_take_o, got_o, ser_stb_o, ir_stb_o} = 4'h0;
        {got_byte_o, ser_byte_o, ir_byte_o} = 24'h0;
    end
    // take every other cycle so the head settles between pops
    always @(posedge clk_i) begin
        tx_take_o <= tx_valid_i && !stall_i && !tx_take_o;
        got_o <= tx_take_o;
        if (tx_take_o) got_byte_o <= tx_byte_i;
    end
    // idle data shows the inverse of the last byte
    task automatic send(input usb_byte_t b, input logic ir);
        @(posedge clk_i);
        if (ir) {ir_stb_o, ir_byte_o} <= {1'b1, b};
        else {ser_stb_o, ser_byte_o} <= {1'b1, b};
        @(posedge clk_i);
        {ir_stb_o, ser_stb_o} <= 2'b00;
        if (ir) ir_byte_o <= ~b;
        else ser_byte_o <= ~b;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

/* File: tb/test_usb_top.sv */
// self-checking bench for shadow buffer access and fifo status
`timescale 1ns/100ps
`include "usb_cfg.svh"
module test_usb_top;
    import usb_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stall = 1, got_err, ack_o, err_o;
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, seed = 32'ha523;
    logic [3:0] sel = 4'h0;
    logic tx_take, tx_valid_o, tx_ir_sel_n_o, rxv, hold_empty, irq_o, got, s_stb, i_stb;
    usb_byte_t tx_byte_o, got_byte, s_byte, i_byte, b, rxe[$];
    logic [63:0] rq[$];
    usb_byte_t txq[$];
    int n_mismatch = 0, checked = 0;
    always #5 clk_i = ~clk_i;
    usb_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .rx_serial_strobe_i(s_stb), .rx_serial_byte_i(s_byte), .rx_ir_strobe_i(i_stb),
        .rx_ir_byte_i(i_byte), .tx_take_i(tx_take), .tx_valid_o(tx_valid_o),
        .tx_byte_o(tx_byte_o), .tx_ir_sel_n_o(tx_ir_sel_n_o), .rx_valid_flag_o(rxv),
        .tx_holding_empty_flag_o(hold_empty), .overrun_o(), .fifo_enable_o(), .irq_o(irq_o));
    usb_peer peer (.clk_i(clk_i), .stall_i(stall), .tx_valid_i(tx_valid_o),
        .tx_byte_i(tx_byte_o), .tx_take_o(tx_take), .got_o(got), .got_byte_o(got_byte),
        .ser_stb_o(s_stb), .ser_byte_o(s_byte), .ir_stb_o(i_stb), .ir_byte_o(i_byte));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // read notes carry mask and expected value
    task automatic bus(input logic w, input logic [31:0] a, d, m, e);
        if (!w && m != 0) rq.push_back({m, e});
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
        // hold until the answer; only the watchdog ends a hang
        do @(posedge clk_i); while (!(ack_o || err_o));
        got_err = err_o;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        if (ack_o && !we && rq.size() > 0) begin
            check(dat_o & rq[0][63:32], rq[0][31:0]);
            void'(rq.pop_front());
        end
        if (got) check(got_byte, txq.size() ? txq.pop_front() : 8'h00);
    end
    initial begin
        #100000;
        n_mismatch++;
        conclude;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `USB_STATUS_ADDR, 0, 32'hFFFFFFFF, 32'h6);
        bus(1, `USB_SHADOW_BASE, 32'hA5, 0, 0);
        bus(1, `USB_SHADOW_LAST, 32'h3C, 0, 0);
        check(hold_empty, 0);
        txq.push_back(8'h3C);
        stall <= 0;
        repeat (10) @(posedge clk_i);
        bus(1, `USB_CTRL_ADDR, 32'h1, 0, 0);
        stall <= 1;
        for (int i = 0; i < 17; i++) begin
            b = $random(seed);
            if (i < 16) txq.push_back(b);
            bus(1, `USB_SHADOW_BASE + 4 * (i % 16), {24'h0, b}, 0, 0);
        end
        bus(0, `USB_STATUS_ADDR, 0, 32'h1F, 32'h0);
        stall <= 0;
        repeat (50) @(posedge clk_i);
        bus(0, `USB_STATUS_ADDR, 0, 32'h1F, 32'h6);
        for (int i = 0; i < 17; i++) begin
            b = $random(seed);
            if (i < 16) rxe.push_back(b);
            peer.send(b, 0);
        end
        bus(0, `USB_STATUS_ADDR, 0, 32'h1F, 32'h1E);
        for (int i = 0; i < 16; i++) begin
            check(rxv, 1);
            bus(0, `USB_SHADOW_BASE + 4 * ((i * 7) % 16), 0, 32'hFF, rxe.pop_front());
        end
        bus(0, `USB_STATUS_ADDR, 0, 32'h1F, 32'h6);
        bus(0, `USB_IRQ_STAT_ADDR, 0, 32'h1, 32'h1);
        bus(1, `USB_IRQ_MASK_ADDR, 32'h0, 0, 0);
        check(irq_o, 0);
        bus(1, `USB_IRQ_MASK_ADDR, 32'h1, 0, 0);
        check(irq_o, 1);
        bus(1, `USB_IRQ_STAT_ADDR, 32'h7, 0, 0);
        check(irq_o, 0);
        bus(1, `USB_CTRL_ADDR, 32'h0, 0, 0);
        peer.send(8'h81, 0);
        peer.send(8'h7E, 0);
        bus(0, `USB_SHADOW_BASE + 20, 0, 32'hFF, 32'h7E);
        check(irq_o, 1);
        bus(1, `USB_CTRL_ADDR, 32'h2, 0, 0);
        check(tx_ir_sel_n_o, 0);
        peer.send(8'hC3, 1);
        check(rxv, 1);
        bus(0, `USB_SHADOW_LAST, 0, 32'hFF, 32'hC3);
        txq.push_back(8'h5A);
        bus(1, `USB_SHADOW_BASE + 8, 32'h5A, 0, 0);
        repeat (10) @(posedge clk_i);
        bus(0, 32'h5000_1200, 0, 0, 0);
        check(got_err, 1);
        check(txq.size(), 0);
        conclude;
    end
endmodule
